/* File: logic/sccs_pkg.sv */
package sccs_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXHOLD = 8'h08;
  localparam logic [7:0] ADDR_RXHOLD = 8'h0c;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  // Control register fields
  localparam int CTL_TXEN = 5;
  localparam int CTL_RXEN = 4;
  localparam int CTL_TX_END_IRQ_ENABLE = 2;
  localparam int CTL_CLOCK_EXT_SELECT = 1;
  localparam int CTL_CLOCK_OUT_SELECT = 0;
  // Status register fields
  localparam int ST_TX_HOLDING_EMPTY = 7;
  localparam int ST_RX_HOLDING_FULL = 6;
  localparam int ST_OER = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  localparam int ST_TX_COMPLETE = 2;
  localparam int ST_MP_BIT_RECEIVED = 1;
  localparam int ST_MP_BIT_TRANSMIT = 0;
  // Mode register fields
  localparam int MODE_SYNC = 0;
  localparam int MODE_LOWPWR = 1;
  // Reset values and write masks
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STATUS_CLEARABLE = 8'hf8;
  // Timing: oversampling and internal divider
  localparam int CLK_HZ = 20000000;
  localparam int DEF_BAUD = 9600;
  localparam int OS_PER_BIT = 16;
  localparam int OS_MID = 8;
  localparam int DEF_OS_DIV = CLK_HZ / (DEF_BAUD * OS_PER_BIT);
  // Ticks from the clock selector
  typedef struct packed {
    logic os;
    logic shift;
    logic sample;
  } sccs_tick_t;
  // Clock selector state
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [15:0] div_cnt;
    logic [3:0] os_cnt;
    logic sck_o;
    logic sck_oe;
    sccs_tick_t tick;
  } sccs_clk_state_t;
  // Transmitter states
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } sccs_tx_state_t;
  // Receiver states
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } sccs_rx_state_t;
  // Top-level state
  typedef struct packed {
    logic rxd_meta;
    logic rxd_sync;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] status;
    logic [7:0] armed;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    sccs_tx_state_t tx_st;
    sccs_rx_state_t rx_st;
    logic [3:0] tx_os;
    logic [3:0] rx_os;
    logic [2:0] tx_bits;
    logic [2:0] rx_bits;
    logic txd;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sccs_state_t;
endpackage

/* File: logic/sccs_clk_sel.sv */
`timescale 1ns/1ps
// Picks the serial clock source and drives or samples the clock pin
module sccs_clk_sel #(
  parameter int OS_DIV = sccs_pkg::DEF_OS_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clock_ext_select,
  input wire logic clock_out_select,
  input wire logic sync_mode,
  input wire logic sck_i,
  output sccs_pkg::sccs_tick_t tick,
  output logic sck_o,
  output logic sck_oe
);
  sccs_pkg::sccs_clk_state_t s_r; // Registered state
  sccs_pkg::sccs_clk_state_t s_nxt; // Next state
  logic rise; // Pin rising edge
  logic fall; // Pin falling edge
  logic reserved; // Reserved select code
  logic int_os; // Internal oversample tick

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_meta = sck_i;
    s_nxt.pin_sync = s_r.pin_meta;
    s_nxt.pin_prev = s_r.pin_sync;
    s_nxt.tick = '0;
    rise = s_r.pin_sync & ~s_r.pin_prev;
    fall = ~s_r.pin_sync & s_r.pin_prev;
    reserved = (clock_ext_select & clock_out_select) | (sync_mode & ~clock_ext_select & clock_out_select);
    int_os = 1'b0;
    // Internal divider runs only for the internal source
    if (!clock_ext_select && !reserved) begin
      if (s_r.div_cnt == 16'(OS_DIV - 1)) begin
        s_nxt.div_cnt = '0;
        s_nxt.os_cnt = s_r.os_cnt + 4'h1;
        int_os = 1'b1;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 16'h1;
      end
    end
    if (reserved) begin
      s_nxt.tick = '0;
    end else if (sync_mode && !clock_ext_select) begin
      s_nxt.tick.shift = int_os & (s_nxt.os_cnt == 4'h8);
      s_nxt.tick.sample = int_os & (s_nxt.os_cnt == 4'h0);
    end else if (sync_mode) begin
      s_nxt.tick.shift = fall;
      s_nxt.tick.sample = rise;
    end else if (clock_ext_select) begin
      s_nxt.tick.os = rise;
    end else begin
      s_nxt.tick.os = int_os;
    end
    // Pin drive: one bit-rate period per sixteen oversample ticks
    s_nxt.sck_oe = ~clock_ext_select & ~reserved & (sync_mode | clock_out_select);
    s_nxt.sck_o = ~s_nxt.os_cnt[3];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
  assign sck_o = s_r.sck_o;
  assign sck_oe = s_r.sck_oe;
endmodule

/* File: logic/sccs_top.sv */
`timescale 1ns/1ps
module sccs_top #(
  parameter int OS_DIV = sccs_pkg::DEF_OS_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  output logic tx_end_irq
);
  sccs_pkg::sccs_state_t s_r; // Registered state
  sccs_pkg::sccs_state_t s_nxt; // Next state
  sccs_pkg::sccs_tick_t tick; // Serial timing ticks
  logic setup; // APB setup cycle
  logic wr; // Write taking effect
  logic rd; // Read completing
  logic sync_mode; // Synchronous mode
  logic reserved; // Reserved clock select
  logic rx_halt; // Reception blocked by errors
  logic tx_halt; // Transmission blocked
  logic [7:0] clr; // Flags cleared by software
  logic [7:0] rx_char; // Character being completed

  // Address decode for the error answer; reads decode by their own case
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == sccs_pkg::ADDR_CONTROL) || (a == sccs_pkg::ADDR_STATUS) ||
             (a == sccs_pkg::ADDR_TXHOLD) || (a == sccs_pkg::ADDR_RXHOLD) ||
             (a == sccs_pkg::ADDR_MODE);
  endfunction

  // Clock source selection and pin handling
  sccs_clk_sel #(
    .OS_DIV(OS_DIV)
  ) u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .clock_ext_select(s_r.ctrl[sccs_pkg::CTL_CLOCK_EXT_SELECT]),
    .clock_out_select(s_r.ctrl[sccs_pkg::CTL_CLOCK_OUT_SELECT]),
    .sync_mode(s_r.mode[sccs_pkg::MODE_SYNC]),
    .sck_i(serial_clock_pin_i),
    .tick(tick),
    .sck_o(serial_clock_pin_o),
    .sck_oe(serial_clock_pin_oe)
  );

  // Next-state logic: bus, flags, transmitter, receiver
  always_comb begin
    s_nxt = s_r;
    clr = '0;
    rx_char = '0;
    s_nxt.rxd_meta = rxd;
    s_nxt.rxd_sync = s_r.rxd_meta;
    sync_mode = s_r.mode[sccs_pkg::MODE_SYNC];
    reserved = (s_r.ctrl[sccs_pkg::CTL_CLOCK_EXT_SELECT] & s_r.ctrl[sccs_pkg::CTL_CLOCK_OUT_SELECT]) |
               (sync_mode & ~s_r.ctrl[sccs_pkg::CTL_CLOCK_EXT_SELECT] &
                s_r.ctrl[sccs_pkg::CTL_CLOCK_OUT_SELECT]);
    rx_halt = s_r.status[sccs_pkg::ST_OER] | s_r.status[sccs_pkg::ST_FER] |
              s_r.status[sccs_pkg::ST_PER];
    tx_halt = reserved | (sync_mode & rx_halt);
    setup = psel & ~penable;
    wr = psel & penable & s_r.pready & pwrite;
    rd = psel & penable & s_r.pready & ~pwrite;
    // Answer one cycle after setup
    s_nxt.pready = setup;
    s_nxt.pslverr = setup & ~mapped(paddr);
    if (setup && !pwrite) begin
      case (paddr)
        sccs_pkg::ADDR_CONTROL: s_nxt.prdata = {24'h0, s_r.ctrl};
        sccs_pkg::ADDR_STATUS: s_nxt.prdata = {24'h0, s_r.status};
        sccs_pkg::ADDR_TXHOLD: s_nxt.prdata = {24'h0, s_r.tx_hold};
        sccs_pkg::ADDR_RXHOLD: s_nxt.prdata = {24'h0, s_r.rx_hold};
        sccs_pkg::ADDR_MODE: s_nxt.prdata = {24'h0, s_r.mode};
        default: s_nxt.prdata = 32'h0;
      endcase
    end
    // Reads: arm flags seen as one, empty receive holding
    if (rd && paddr == sccs_pkg::ADDR_STATUS) begin
      s_nxt.armed = s_r.armed | (s_r.prdata[7:0] & sccs_pkg::STATUS_CLEARABLE);
    end
    if (rd && paddr == sccs_pkg::ADDR_RXHOLD) begin
      clr[sccs_pkg::ST_RX_HOLDING_FULL] = 1'b1;
    end
    // Writes
    if (wr) begin
      case (paddr)
        sccs_pkg::ADDR_CONTROL: s_nxt.ctrl = pwdata[7:0];
        sccs_pkg::ADDR_MODE: s_nxt.mode = pwdata[7:0];
        sccs_pkg::ADDR_STATUS: begin
          clr = ~pwdata[7:0] & s_r.armed & sccs_pkg::STATUS_CLEARABLE;
          s_nxt.status[sccs_pkg::ST_MP_BIT_TRANSMIT] = pwdata[sccs_pkg::ST_MP_BIT_TRANSMIT];
        end
        sccs_pkg::ADDR_TXHOLD: begin
          s_nxt.tx_hold = pwdata[7:0];
          clr[sccs_pkg::ST_TX_HOLDING_EMPTY] = 1'b1;
          clr[sccs_pkg::ST_TX_COMPLETE] = 1'b1;
        end
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    // Clearing first; hardware sets below override it
    s_nxt.status = s_nxt.status & ~clr;
    s_nxt.armed = s_nxt.armed & ~clr;
    // Transmitter
    if (!s_r.ctrl[sccs_pkg::CTL_TXEN]) begin
      s_nxt.status[sccs_pkg::ST_TX_HOLDING_EMPTY] = 1'b1;
      s_nxt.status[sccs_pkg::ST_TX_COMPLETE] = 1'b1;
      s_nxt.tx_st = sccs_pkg::TX_IDLE;
      s_nxt.txd = 1'b1;
    end else begin
      case (s_r.tx_st)
        sccs_pkg::TX_IDLE: begin
          s_nxt.txd = 1'b1;
          if (!s_r.status[sccs_pkg::ST_TX_HOLDING_EMPTY] && !tx_halt) begin
            s_nxt.tx_shift = s_r.tx_hold;
            s_nxt.status[sccs_pkg::ST_TX_HOLDING_EMPTY] = 1'b1;
            s_nxt.tx_os = '0;
            s_nxt.tx_bits = '0;
            if (sync_mode) begin
              s_nxt.tx_st = sccs_pkg::TX_DATA;
              s_nxt.txd = s_r.tx_hold[0];
            end else begin
              s_nxt.tx_st = sccs_pkg::TX_START;
              s_nxt.txd = 1'b0;
            end
          end
        end
        sccs_pkg::TX_START: begin
          if (tick.os) begin
            s_nxt.tx_os = s_r.tx_os + 4'h1;
            if (s_r.tx_os == 4'(sccs_pkg::OS_PER_BIT - 1)) begin
              s_nxt.tx_st = sccs_pkg::TX_DATA;
              s_nxt.txd = s_r.tx_shift[0];
            end
          end
        end
        sccs_pkg::TX_DATA: begin
          if ((sync_mode && tick.shift) ||
              (!sync_mode && tick.os && s_r.tx_os == 4'(sccs_pkg::OS_PER_BIT - 1))) begin
            s_nxt.tx_shift = {1'b1, s_r.tx_shift[7:1]};
            s_nxt.tx_bits = s_r.tx_bits + 3'h1;
            s_nxt.txd = s_r.tx_shift[1];
            if (s_r.tx_bits == 3'h7) begin
              if (!sync_mode) begin
                s_nxt.tx_st = sccs_pkg::TX_STOP;
                s_nxt.txd = 1'b1;
              end else if (!s_r.status[sccs_pkg::ST_TX_HOLDING_EMPTY] && !tx_halt) begin
                s_nxt.tx_shift = s_r.tx_hold; // Back-to-back character
                s_nxt.txd = s_r.tx_hold[0];
                s_nxt.status[sccs_pkg::ST_TX_HOLDING_EMPTY] = 1'b1;
              end else begin
                s_nxt.tx_st = sccs_pkg::TX_IDLE;
                s_nxt.status[sccs_pkg::ST_TX_COMPLETE] = 1'b1;
              end
            end
          end
          if (!sync_mode && tick.os) begin
            s_nxt.tx_os = s_r.tx_os + 4'h1;
          end
        end
        sccs_pkg::TX_STOP: begin
          if (tick.os) begin
            s_nxt.tx_os = s_r.tx_os + 4'h1;
            if (s_r.tx_os == 4'(sccs_pkg::OS_PER_BIT - 1)) begin
              s_nxt.tx_st = sccs_pkg::TX_IDLE;
              if (s_r.status[sccs_pkg::ST_TX_HOLDING_EMPTY]) begin
                s_nxt.status[sccs_pkg::ST_TX_COMPLETE] = 1'b1;
              end
            end
          end
        end
        default: s_nxt.tx_st = sccs_pkg::TX_IDLE;
      endcase
    end
    // Receiver; disabling it leaves every flag alone
    if (!s_r.ctrl[sccs_pkg::CTL_RXEN] || reserved) begin
      s_nxt.rx_st = sccs_pkg::RX_IDLE;
    end else begin
      case (s_r.rx_st)
        sccs_pkg::RX_IDLE: begin
          s_nxt.rx_os = '0;
          s_nxt.rx_bits = '0;
          if (!rx_halt) begin
            if (sync_mode) begin
              s_nxt.rx_st = sccs_pkg::RX_DATA;
            end else if (!s_r.rxd_sync) begin
              s_nxt.rx_st = sccs_pkg::RX_START;
            end
          end
        end
        sccs_pkg::RX_START: begin
          if (tick.os) begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
            if (s_r.rx_os == 4'(sccs_pkg::OS_MID - 1)) begin
              s_nxt.rx_os = '0;
              s_nxt.rx_st = s_r.rxd_sync ? sccs_pkg::RX_IDLE : sccs_pkg::RX_DATA;
            end
          end
        end
        sccs_pkg::RX_DATA: begin
          if (!sync_mode && tick.os) begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
          end
          if ((sync_mode && tick.sample) ||
              (!sync_mode && tick.os && s_r.rx_os == 4'(sccs_pkg::OS_PER_BIT - 1))) begin
            s_nxt.rx_shift = {s_r.rxd_sync, s_r.rx_shift[7:1]};
            s_nxt.rx_bits = s_r.rx_bits + 3'h1;
            if (s_r.rx_bits == 3'h7) begin
              s_nxt.rx_st = sync_mode ? sccs_pkg::RX_IDLE : sccs_pkg::RX_STOP;
              if (sync_mode) begin
                rx_char = {s_r.rxd_sync, s_r.rx_shift[7:1]};
                if (s_r.status[sccs_pkg::ST_RX_HOLDING_FULL]) begin
                  s_nxt.status[sccs_pkg::ST_OER] = 1'b1;
                end else begin
                  s_nxt.rx_hold = rx_char;
                  s_nxt.status[sccs_pkg::ST_RX_HOLDING_FULL] = 1'b1;
                end
              end
            end
          end
        end
        sccs_pkg::RX_STOP: begin
          if (tick.os) begin
            s_nxt.rx_os = s_r.rx_os + 4'h1;
            if (s_r.rx_os == 4'(sccs_pkg::OS_PER_BIT - 1)) begin
              s_nxt.rx_st = sccs_pkg::RX_IDLE;
              if (!s_r.rxd_sync) begin
                s_nxt.status[sccs_pkg::ST_FER] = 1'b1;
              end else if (s_r.status[sccs_pkg::ST_RX_HOLDING_FULL]) begin
                s_nxt.status[sccs_pkg::ST_OER] = 1'b1;
              end else begin
                s_nxt.rx_hold = s_r.rx_shift;
                s_nxt.status[sccs_pkg::ST_RX_HOLDING_FULL] = 1'b1;
              end
            end
          end
        end
        default: s_nxt.rx_st = sccs_pkg::RX_IDLE;
      endcase
    end
    // Low-power mode reinitialises the status register
    if (s_r.mode[sccs_pkg::MODE_LOWPWR]) begin
      s_nxt.status = sccs_pkg::STATUS_RESET;
      s_nxt.armed = '0;
      s_nxt.tx_st = sccs_pkg::TX_IDLE;
      s_nxt.rx_st = sccs_pkg::RX_IDLE;
      s_nxt.txd = 1'b1;
    end
    // Transmit-end request
    s_nxt.irq = s_nxt.ctrl[sccs_pkg::CTL_TX_END_IRQ_ENABLE] & s_nxt.status[sccs_pkg::ST_TX_HOLDING_EMPTY] &
                s_nxt.status[sccs_pkg::ST_TX_COMPLETE];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= sccs_pkg::CONTROL_RESET;
      s_r.mode <= sccs_pkg::MODE_RESET;
      s_r.status <= sccs_pkg::STATUS_RESET;
      s_r.tx_st <= sccs_pkg::TX_IDLE;
      s_r.rx_st <= sccs_pkg::RX_IDLE;
      s_r.txd <= 1'b1;
      s_r.rxd_meta <= 1'b1;
      s_r.rxd_sync <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign txd = s_r.txd;
  assign tx_end_irq = s_r.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Status write of zeros at the completing edge
  sequence status_zero_write;
    psel && penable && pready && pwrite && paddr == sccs_pkg::ADDR_STATUS &&
      pwdata[7:0] == 8'h00;
  endsequence

  a_irq_enable_off: assert property (
    !s_r.ctrl[sccs_pkg::CTL_TX_END_IRQ_ENABLE] |-> !tx_end_irq)
    else $error("transmit-end request with enable clear");
  a_irq_flags_on: assert property (
    s_r.ctrl[sccs_pkg::CTL_TX_END_IRQ_ENABLE] && s_r.status[sccs_pkg::ST_TX_HOLDING_EMPTY] &&
      s_r.status[sccs_pkg::ST_TX_COMPLETE] && !wr && !s_r.mode[sccs_pkg::MODE_LOWPWR]
      |=> tx_end_irq)
    else $error("transmit-end request missing");
  a_reserved_no_drive: assert property (
    s_r.ctrl[sccs_pkg::CTL_CLOCK_EXT_SELECT] && s_r.ctrl[sccs_pkg::CTL_CLOCK_OUT_SELECT] ##1 $stable(s_r.ctrl)
      |=> !serial_clock_pin_oe)
    else $error("clock pin driven under reserved select");
  a_unarmed_clear: assert property (
    status_zero_write and (s_r.armed == 8'h00 && !s_r.mode[sccs_pkg::MODE_LOWPWR])
      |=> s_r.status[sccs_pkg::ST_OER] == $past(s_r.status[sccs_pkg::ST_OER]) ||
          $past(s_r.status[sccs_pkg::ST_OER]) == 1'b0)
    else $error("overrun cleared without prior read");
  a_readonly_keep: assert property (
    status_zero_write and (!s_r.mode[sccs_pkg::MODE_LOWPWR] &&
      s_r.rx_st == sccs_pkg::RX_IDLE && s_r.tx_st == sccs_pkg::TX_IDLE &&
      s_r.ctrl[sccs_pkg::CTL_TXEN])
      |=> $stable(s_r.status[sccs_pkg::ST_TX_COMPLETE]) && $stable(s_r.status[sccs_pkg::ST_MP_BIT_RECEIVED]))
    else $error("read-only status bit changed by write");
  a_txhold_clears: assert property (
    wr && paddr == sccs_pkg::ADDR_TXHOLD && s_r.ctrl[sccs_pkg::CTL_TXEN] &&
      !s_r.mode[sccs_pkg::MODE_LOWPWR] |=> !s_r.status[sccs_pkg::ST_TX_HOLDING_EMPTY])
    else $error("holding-empty not cleared by data write");
  a_tx_off_empty: assert property (
    !s_r.ctrl[sccs_pkg::CTL_TXEN] |=> s_r.status[sccs_pkg::ST_TX_HOLDING_EMPTY] &&
      s_r.status[sccs_pkg::ST_TX_COMPLETE])
    else $error("holding-empty not set with transmit off");
  a_rxhold_read: assert property (
    rd && paddr == sccs_pkg::ADDR_RXHOLD && s_r.rx_st != sccs_pkg::RX_STOP &&
      s_r.rx_st != sccs_pkg::RX_DATA |=> !s_r.status[sccs_pkg::ST_RX_HOLDING_FULL])
    else $error("receive-full not cleared by data read");
  a_overrun_keep: assert property (
    s_r.status[sccs_pkg::ST_RX_HOLDING_FULL] && !rd && !wr |=> $stable(s_r.rx_hold))
    else $error("receive holding overwritten while full");
  a_overrun_halt: assert property (
    s_r.status[sccs_pkg::ST_OER] && s_r.rx_st == sccs_pkg::RX_IDLE
      |=> s_r.rx_st == sccs_pkg::RX_IDLE)
    else $error("reception restarted during overrun");
  a_rx_off_keep: assert property (
    !s_r.ctrl[sccs_pkg::CTL_RXEN] && !wr && !s_r.mode[sccs_pkg::MODE_LOWPWR]
      |=> $stable(s_r.status[sccs_pkg::ST_OER]))
    else $error("overrun changed with receive off");
endmodule

/* File: sim/sccs_peer.sv */
`timescale 1ns/1ps
// Remote serial peer: drives the receive line and the link clock, listens to transmit
module sccs_peer (
  output logic rxd,
  output logic link_clk,
  input wire logic txd
);
  // Link clock runs only while a frame is under way
  logic run;
  initial begin
    rxd = 1'b1;
    link_clk = 1'b0;
    run = 1'b0;
  end
  // Period 400 ns, sixteen of them to one bit; stands low outside frames
  initial forever #200 link_clk = run ? ~link_clk : 1'b0;
  // One 8N1 character, LSB first, with idle time around it
  task automatic send(input logic [7:0] d, input int bit_ns, input logic ext);
    run = ext;
    #(bit_ns);
    rxd = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      #(bit_ns);
    end
    rxd = 1'b1;
    #(2 * bit_ns);
    run = 1'b0;
  endtask
  // Samples one character at mid-bit; returns in the stop bit
  task automatic recv(input int bit_ns, output logic [7:0] d);
    @(negedge txd);
    #(bit_ns * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      d[i] = txd;
      #(bit_ns);
    end
  endtask
endmodule

/* File: sim/tb_serial_clock_select_and_status.sv */
`timescale 1ns/1ps
module tb_serial_clock_select_and_status;
  localparam int OS_DIV = 2; // Short divider keeps runs brief
  localparam int BIT_NS = 16 * OS_DIV * 50; // One internal bit
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr, b1, b2, got;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rxd, txd, sck_i, sck_o, sck_oe, tx_end_irq, link_clk;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  real t0;
  sccs_top #(.OS_DIV(OS_DIV)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .serial_clock_pin_i(sck_i), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .tx_end_irq(tx_end_irq)
  );
  sccs_peer peer (.rxd(rxd), .link_clk(link_clk), .txd(txd));
  // Clock pin level: the device wins while it drives
  assign sck_i = sck_oe ? sck_o : link_clk;
  // Bus clock, 50 ns
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // Value compare
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected clock pin drive per mode and select
  function automatic logic oe_exp(input logic s, input logic [1:0] c);
    return s ? (c == 2'b00) : (c == 2'b01);
  endfunction
  task automatic test_done(input string n);
    $display("Test %s finished", n);
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h93bb5fca));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unarmed clear, unmapped place
    apb(1'b1, sccs_pkg::ADDR_STATUS, 8'h00);
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(rd, 32'h84, "status reset");
    apb(1'b0, sccs_pkg::ADDR_CONTROL, 8'h00);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, 8'h20, 8'h00);
    chk(32'(err), 32'h1, "unmapped error");
    test_done("reset");
    // Every select code in both modes; select written before mode
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, sccs_pkg::ADDR_CONTROL, {6'h0, i[1:0]});
      apb(1'b1, sccs_pkg::ADDR_MODE, {7'h0, i[2]});
      repeat (4) @(posedge pclk);
      chk(32'(sck_oe), 32'(oe_exp(i[2], i[1:0])), "pin drive");
    end
    apb(1'b1, sccs_pkg::ADDR_MODE, 8'h00);
    apb(1'b1, sccs_pkg::ADDR_CONTROL, 8'h01);
    @(posedge sck_o);
    t0 = $realtime;
    @(posedge sck_o);
    chk(32'($rtoi($realtime - t0)), BIT_NS, "clock out period");
    test_done("clock select");
    // Clean character, then read clears full
    apb(1'b1, sccs_pkg::ADDR_CONTROL, 8'h10);
    b1 = 8'($urandom);
    peer.send(b1, BIT_NS, 1'b0);
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(32'(rd[6]), 32'h1, "rx full set");
    apb(1'b0, sccs_pkg::ADDR_RXHOLD, 8'h00);
    chk(rd, {24'h0, b1}, "rx data");
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(32'(rd[6]), 32'h0, "rx full cleared");
    test_done("receive");
    // Overrun: old data kept, reception halts, disable keeps flag
    b2 = 8'($urandom);
    peer.send(b2, BIT_NS, 1'b0);
    peer.send(~b2, BIT_NS, 1'b0);
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(32'(rd[6:5]), 32'h3, "overrun set");
    apb(1'b0, sccs_pkg::ADDR_RXHOLD, 8'h00);
    chk(rd, {24'h0, b2}, "old data kept");
    peer.send(b1, BIT_NS, 1'b0);
    apb(1'b1, sccs_pkg::ADDR_CONTROL, 8'h00);
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(32'(rd[6:5]), 32'h1, "halted, flag kept");
    apb(1'b0, sccs_pkg::ADDR_RXHOLD, 8'h00);
    chk(rd, {24'h0, b2}, "data unchanged");
    apb(1'b1, sccs_pkg::ADDR_STATUS, 8'h00);
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(32'(rd[5]), 32'h0, "armed clear");
    test_done("overrun");
    // External clock at sixteen times the bit rate, clock out select kept low
    apb(1'b1, sccs_pkg::ADDR_CONTROL, 8'h12);
    b1 = 8'($urandom);
    peer.send(b1, 16 * 400, 1'b1);
    apb(1'b0, sccs_pkg::ADDR_RXHOLD, 8'h00);
    chk(rd, {24'h0, b1}, "external clock rx");
    test_done("external clock");
    // Transmit and end request
    apb(1'b1, sccs_pkg::ADDR_CONTROL, 8'h24);
    repeat (2) @(posedge pclk);
    chk(32'(tx_end_irq), 32'h1, "request idle");
    b2 = 8'($urandom);
    fork
      peer.recv(BIT_NS, got);
      begin
        apb(1'b1, sccs_pkg::ADDR_TXHOLD, b2);
        repeat (3) @(posedge pclk);
        chk(32'(tx_end_irq), 32'h0, "request busy");
        apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
        chk(32'(rd[7]), 32'h1, "moved to shift");
      end
    join
    chk(32'(got), 32'(b2), "tx data");
    repeat (2 * 16 * OS_DIV) @(posedge pclk);
    chk(32'(tx_end_irq), 32'h1, "request at end");
    apb(1'b1, sccs_pkg::ADDR_CONTROL, 8'h20);
    repeat (2) @(posedge pclk);
    chk(32'(tx_end_irq), 32'h0, "request disabled");
    test_done("transmit");
    // Low-power mode reloads status while transmit complete is still clear
    apb(1'b1, sccs_pkg::ADDR_TXHOLD, b1);
    apb(1'b1, sccs_pkg::ADDR_MODE, 8'h02);
    apb(1'b0, sccs_pkg::ADDR_STATUS, 8'h00);
    chk(rd, 32'h84, "low power status");
    test_done("low power");
    end_of_test();
  end
endmodule
